// ### include/usart_cfg_pkg.sv
package usart_cfg_pkg;

    // Register byte offsets on the peripheral bus
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_MODE = 8'h04;
    localparam logic [7:0] OFS_IEN_SET = 8'h08;
    localparam logic [7:0] OFS_IEN_CLR = 8'h0c;
    localparam logic [7:0] OFS_IEN_VIEW = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_TO_VALUE = 8'h24;

    // Command register bit positions
    localparam int CTRL_BEGIN_TO_BIT = 11;
    localparam int CTRL_SEND_ADDR_BIT = 12;

    // Mode register field positions
    localparam int BAUD_SRC_LSB = 4;
    localparam int CHAR_SIZE_LSB = 6;
    localparam int SYNC_BIT = 8;
    localparam int CHECK_LSB = 9;
    localparam int STOP_LSB = 12;
    localparam int LOOP_LSB = 14;
    localparam int NINE_BIT = 17;
    localparam int DRIVE_CLK_BIT = 18;
    localparam logic [31:0] MODE_WR_MASK = 32'h0006_fff0;
    localparam logic [31:0] MODE_RESET = 32'h0000_0000;

    // Interrupt source layout
    localparam int IRQ_NUM = 10;
    localparam int IRQ_TIMEOUT_BIT = 8;
    localparam logic [IRQ_NUM-1:0] IRQ_MASK_RESET = 10'h000;

    // Field encodings
    localparam logic [1:0] SRC_MASTER = 2'h0;
    localparam logic [1:0] SRC_MASTER_DIV = 2'h1;
    localparam logic [2:0] MASTER_DIV_LAST = 3'h7;
    localparam logic [1:0] LOOP_NORMAL = 2'h0;
    localparam logic [1:0] LOOP_ECHO = 2'h1;
    localparam logic [1:0] LOOP_LOCAL = 2'h2;
    localparam logic [1:0] LOOP_REMOTE = 2'h3;
    localparam logic [1:0] CHECK_MULTIDROP = 2'h3;
    localparam logic [1:0] CHECK_NONE = 2'h2;
    localparam logic [3:0] CHAR_BASE_BITS = 4'h5;
    localparam logic [3:0] CHAR_NINE_BITS = 4'h9;
    localparam logic [2:0] STOP_HALVES_ONE = 3'h2;
    localparam logic [2:0] STOP_HALVES_ONE_HALF = 3'h3;
    localparam logic [2:0] STOP_HALVES_TWO = 3'h4;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    // Idle time-out sequencer
    typedef enum logic [1:0] {TO_IDLE, TO_WAIT_CHAR, TO_COUNT} to_state_e;

    // Decoded frame format handed to the shifters
    typedef struct packed {
        logic [3:0] data_bits;
        logic parity_on;
        logic [1:0] parity_kind;
        logic multidrop;
        logic [2:0] stop_halves;
        logic sync_mode;
    } frame_cfg_s;

endpackage : usart_cfg_pkg

// ### src/usart_mode_irq.sv
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/1ps
module usart_mode_irq #(
    parameter int TO_WIDTH = 8
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic rxd_pin,
    input wire logic sck_pin_in,
    input wire logic tx_line,
    input wire logic rx_char_start,
    input wire logic thr_load,
    input wire logic timeout_tick,
    input wire logic [usart_cfg_pkg::IRQ_NUM-1:0] status_in,
    output logic txd_pin,
    output logic rx_line,
    output logic sck_pin_out,
    output logic sck_pin_oe,
    output logic baud_tick,
    output logic tx_addr_bit,
    output usart_cfg_pkg::frame_cfg_s frame_cfg,
    output logic [usart_cfg_pkg::IRQ_NUM-1:0] irq_mask,
    output logic irq
);
    import usart_cfg_pkg::*;

    // The counter width must fit the 16-bit value field of the register
    if (TO_WIDTH < 1 || TO_WIDTH > 16) begin : g_bad_width
        $error("TO_WIDTH must lie between 1 and 16");
    end

    typedef struct packed {
        logic pend_wr;
        logic [7:0] pend_addr;
        logic readyout;
        logic [31:0] rdata;
        logic [31:0] mode;
        logic [IRQ_NUM-1:0] mask;
        logic [TO_WIDTH-1:0] to_value;
        logic [TO_WIDTH-1:0] to_count;
        to_state_e to_state;
        logic to_flag;
        logic addr_armed;
        logic addr_bit;
        logic [1:0] rxd_sync;
        logic [1:0] sck_sync;
        logic sck_prev;
        logic [2:0] div_cnt;
        logic baud_tick;
        logic txd;
        logic rx_line;
        logic sck_out;
        logic sck_oe;
        frame_cfg_s cfg;
        logic irq;
    } state_s;

    state_s st_ff;
    state_s nxt_st;

    // Word match on the low address byte; upper lanes are not decoded
    function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
        reg_hit = (addr[7:2] == ofs[7:2]);
    endfunction : reg_hit

    logic [1:0] baud_src;
    logic [1:0] loop_sel;
    logic [1:0] check_hi;
    logic [IRQ_NUM-1:0] status_all;
    logic addr_phase;

    // Field views of the live mode register
    assign baud_src = st_ff.mode[BAUD_SRC_LSB +: 2];
    assign loop_sel = st_ff.mode[LOOP_LSB +: 2];
    assign check_hi = st_ff.mode[CHECK_LSB + 1 +: 2];
    assign addr_phase = hsel && hready && htrans[1];

    // Time-out flag replaces its slot; the other nine come from the datapath
    always_comb begin
        status_all = status_in;
        status_all[IRQ_TIMEOUT_BIT] = st_ff.to_flag;
    end

    // Next-state logic for bus, configuration, time-out and pin routing
    always_comb begin
        logic wr_ctrl;
        logic set_to;
        logic [IRQ_NUM-1:0] en_bits;
        logic [IRQ_NUM-1:0] dis_bits;
        wr_ctrl = 1'b0;
        set_to = 1'b0;
        en_bits = '0;
        dis_bits = '0;
        nxt_st = st_ff;

        // Zero-wait slave: write data lands one cycle after its address phase
        nxt_st.readyout = 1'b1;
        nxt_st.pend_wr = addr_phase && hwrite;
        if (addr_phase) begin
            nxt_st.pend_addr = haddr[7:0];
        end
        nxt_st.rdata = '0;
        if (addr_phase && !hwrite) begin
            if (reg_hit(haddr[7:0], OFS_MODE)) begin
                nxt_st.rdata = st_ff.mode;
            end else if (reg_hit(haddr[7:0], OFS_IEN_VIEW)) begin
                nxt_st.rdata = {{(32 - IRQ_NUM){1'b0}}, st_ff.mask};
            end else if (reg_hit(haddr[7:0], OFS_STATUS)) begin
                nxt_st.rdata = {{(32 - IRQ_NUM){1'b0}}, status_all};
            end else if (reg_hit(haddr[7:0], OFS_TO_VALUE)) begin
                nxt_st.rdata = {{(32 - TO_WIDTH){1'b0}}, st_ff.to_value};
            end
        end

        // Register writes; reserved bits are dropped at the door
        if (st_ff.pend_wr) begin
            if (reg_hit(st_ff.pend_addr, OFS_MODE)) begin
                nxt_st.mode = hwdata & MODE_WR_MASK;
            end
            if (reg_hit(st_ff.pend_addr, OFS_IEN_SET)) begin
                en_bits = hwdata[IRQ_NUM-1:0];
            end
            if (reg_hit(st_ff.pend_addr, OFS_IEN_CLR)) begin
                dis_bits = hwdata[IRQ_NUM-1:0];
            end
            if (reg_hit(st_ff.pend_addr, OFS_TO_VALUE)) begin
                nxt_st.to_value = hwdata[TO_WIDTH-1:0];
            end
            wr_ctrl = reg_hit(st_ff.pend_addr, OFS_CTRL);
        end
        nxt_st.mask = (st_ff.mask | en_bits) & ~dis_bits;

        // Idle time-out: wait for a character, then count idle ticks
        case (st_ff.to_state)
            TO_IDLE: begin
                nxt_st.to_state = TO_IDLE;
            end
            TO_WAIT_CHAR: begin
                if (rx_char_start) begin
                    nxt_st.to_count = st_ff.to_value;
                    nxt_st.to_state = TO_COUNT;
                end
            end
            TO_COUNT: begin
                if (st_ff.to_value == '0) begin
                    nxt_st.to_state = TO_IDLE;
                end else if (rx_char_start) begin
                    nxt_st.to_count = st_ff.to_value;
                end else if (timeout_tick) begin
                    if (st_ff.to_count <= TO_WIDTH'(1)) begin
                        set_to = 1'b1;
                        nxt_st.to_state = TO_IDLE;
                    end else begin
                        nxt_st.to_count = st_ff.to_count - TO_WIDTH'(1);
                    end
                end
            end
            default: begin
                nxt_st.to_state = TO_IDLE;
            end
        endcase
        // A zero value never arms the counter, so the flag cannot appear
        if (wr_ctrl && hwdata[CTRL_BEGIN_TO_BIT]) begin
            nxt_st.to_state = (st_ff.to_value != '0) ? TO_WAIT_CHAR : TO_IDLE;
        end
        // Expiry in the same cycle as a restart is kept: set beats clear
        nxt_st.to_flag = set_to | (st_ff.to_flag & ~(wr_ctrl && hwdata[CTRL_BEGIN_TO_BIT]));

        // Address marker follows the next holding-register load
        if (thr_load) begin
            nxt_st.addr_bit = st_ff.addr_armed;
            nxt_st.addr_armed = 1'b0;
        end
        if (wr_ctrl && hwdata[CTRL_SEND_ADDR_BIT] && check_hi == CHECK_MULTIDROP) begin
            nxt_st.addr_armed = 1'b1;
        end

        // Pin synchronisers; stage zero feeds stage one only
        nxt_st.rxd_sync = {st_ff.rxd_sync[0], rxd_pin};
        nxt_st.sck_sync = {st_ff.sck_sync[0], sck_pin_in};
        nxt_st.sck_prev = st_ff.sck_sync[1];

        // Baud generator input clock as a tick stream
        nxt_st.div_cnt = st_ff.div_cnt + 3'h1;
        if (baud_src == SRC_MASTER) begin
            nxt_st.baud_tick = 1'b1;
        end else if (baud_src == SRC_MASTER_DIV) begin
            nxt_st.baud_tick = (st_ff.div_cnt == MASTER_DIV_LAST);
        end else begin
            nxt_st.baud_tick = st_ff.sck_sync[1] && !st_ff.sck_prev;
        end

        // Clock pin only driven from an internal source
        nxt_st.sck_oe = st_ff.mode[DRIVE_CLK_BIT] && !baud_src[1];
        if (st_ff.baud_tick) begin
            nxt_st.sck_out = !st_ff.sck_out;
        end

        // Channel routing of the serial pins
        case (loop_sel)
            LOOP_NORMAL: begin
                nxt_st.txd = tx_line;
                nxt_st.rx_line = st_ff.rxd_sync[1];
            end
            LOOP_ECHO: begin
                nxt_st.txd = st_ff.rxd_sync[1];
                nxt_st.rx_line = st_ff.rxd_sync[1];
            end
            LOOP_LOCAL: begin
                nxt_st.txd = 1'b1;
                nxt_st.rx_line = tx_line;
            end
            LOOP_REMOTE: begin
                nxt_st.txd = st_ff.rxd_sync[1];
                nxt_st.rx_line = 1'b1;
            end
            default: begin
                nxt_st.txd = 1'b1;
                nxt_st.rx_line = 1'b1;
            end
        endcase

        // Frame format decode
        nxt_st.cfg.data_bits = st_ff.mode[NINE_BIT] ? CHAR_NINE_BITS
            : CHAR_BASE_BITS + {2'h0, st_ff.mode[CHAR_SIZE_LSB +: 2]};
        nxt_st.cfg.sync_mode = st_ff.mode[SYNC_BIT];
        nxt_st.cfg.parity_on = !check_hi[1];
        nxt_st.cfg.parity_kind = st_ff.mode[CHECK_LSB +: 2];
        nxt_st.cfg.multidrop = (check_hi == CHECK_MULTIDROP);
        // Reserved stop codes fall back to one stop bit
        case (st_ff.mode[STOP_LSB +: 2])
            2'h1: nxt_st.cfg.stop_halves = st_ff.mode[SYNC_BIT] ? STOP_HALVES_ONE
                : STOP_HALVES_ONE_HALF;
            2'h2: nxt_st.cfg.stop_halves = STOP_HALVES_TWO;
            default: nxt_st.cfg.stop_halves = STOP_HALVES_ONE;
        endcase

        nxt_st.irq = |(status_all & st_ff.mask);
    end

    // State register; every field takes a constant at reset
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_ff <= '0;
            st_ff.readyout <= 1'b1;
            st_ff.mode <= MODE_RESET;
            st_ff.mask <= IRQ_MASK_RESET;
            st_ff.to_state <= TO_IDLE;
            st_ff.rxd_sync <= 2'h3;
            st_ff.txd <= 1'b1;
            st_ff.rx_line <= 1'b1;
            st_ff.cfg.data_bits <= CHAR_BASE_BITS;
            st_ff.cfg.parity_on <= 1'b1;
            st_ff.cfg.stop_halves <= STOP_HALVES_ONE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign hreadyout = st_ff.readyout;
    assign hresp = 1'b0;
    assign hrdata = st_ff.rdata;
    assign txd_pin = st_ff.txd;
    assign rx_line = st_ff.rx_line;
    assign sck_pin_out = st_ff.sck_out;
    assign sck_pin_oe = st_ff.sck_oe;
    assign baud_tick = st_ff.baud_tick;
    assign tx_addr_bit = st_ff.addr_bit;
    assign frame_cfg = st_ff.cfg;
    assign irq_mask = st_ff.mask;
    assign irq = st_ff.irq;

    // Checks on the block's own outputs and internal state
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    // An expiry tick in the command cycle keeps the flag set, so it is left out here
    sequence s_begin_cmd;
        st_ff.pend_wr && reg_hit(st_ff.pend_addr, OFS_CTRL)
            && hwdata[CTRL_BEGIN_TO_BIT] && st_ff.to_value != '0 && !timeout_tick;
    endsequence
    sequence s_imr_read;
        addr_phase && !hwrite && reg_hit(haddr[7:0], OFS_IEN_VIEW);
    endsequence

    property p_begin_waits;
        s_begin_cmd |=> st_ff.to_state == TO_WAIT_CHAR && !st_ff.to_flag;
    endproperty
    a_begin_waits: assert property (p_begin_waits) else $error("start cmd did not arm");

    property p_addr_marked;
        // A command landing in the load cycle arms again for the following load
        (st_ff.addr_armed && thr_load
            && !(st_ff.pend_wr && reg_hit(st_ff.pend_addr, OFS_CTRL)))
            |=> tx_addr_bit && !st_ff.addr_armed;
    endproperty
    a_addr_marked: assert property (p_addr_marked) else $error("address bit lost");

    property p_master_src;
        (baud_src == SRC_MASTER) ##1 (baud_src == SRC_MASTER) |-> baud_tick;
    endproperty
    a_master_src: assert property (p_master_src) else $error("master tick missing");

    property p_nine_bits;
        st_ff.mode[NINE_BIT] |=> frame_cfg.data_bits == CHAR_NINE_BITS;
    endproperty
    a_nine_bits: assert property (p_nine_bits) else $error("nine-bit length wrong");

    property p_local_loop;
        (loop_sel == LOOP_LOCAL) |=> txd_pin && rx_line == $past(tx_line);
    endproperty
    a_local_loop: assert property (p_local_loop) else $error("local loop routing");

    property p_echo;
        (loop_sel == LOOP_ECHO) |=> txd_pin == $past(st_ff.rxd_sync[1]);
    endproperty
    a_echo: assert property (p_echo) else $error("echo routing");

    property p_ier_sets;
        st_ff.pend_wr && reg_hit(st_ff.pend_addr, OFS_IEN_SET)
            && !reg_hit(st_ff.pend_addr, OFS_IEN_CLR)
            |=> (irq_mask & $past(hwdata[IRQ_NUM-1:0])) == $past(hwdata[IRQ_NUM-1:0]);
    endproperty
    a_ier_sets: assert property (p_ier_sets) else $error("enable write failed");

    property p_idr_clears;
        st_ff.pend_wr && reg_hit(st_ff.pend_addr, OFS_IEN_CLR)
            |=> (irq_mask & $past(hwdata[IRQ_NUM-1:0])) == '0;
    endproperty
    a_idr_clears: assert property (p_idr_clears) else $error("disable write failed");

    property p_imr_read;
        s_imr_read |=> hrdata == {{(32 - IRQ_NUM){1'b0}}, $past(irq_mask)};
    endproperty
    a_imr_read: assert property (p_imr_read) else $error("mask view wrong");

    property p_irq_level;
        ##1 irq == $past(|(status_all & irq_mask));
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

    property p_zero_no_flag;
        (st_ff.to_value == '0 && !st_ff.to_flag) |=> !st_ff.to_flag;
    endproperty
    a_zero_no_flag: assert property (p_zero_no_flag) else $error("flag with zero value");

    property p_sck_drive;
        (st_ff.mode[DRIVE_CLK_BIT] && baud_src[1]) |=> !sck_pin_oe;
    endproperty
    a_sck_drive: assert property (p_sck_drive) else $error("clock pin driven externally");

endmodule : usart_mode_irq

// ### verification/remote_serial_model.sv
`timescale 1ns/1ps
// Far-end serial device: drives the data line and the clock pin, which toggles only while clk_run is high
module remote_serial_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic bit_val,
    input wire logic clk_run,
    output logic rxd_pin,
    output logic sck_pin
);
    int half_cnt;
    // Clock stands still between frames so no stray baud edges reach the block
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            half_cnt <= 0;
            sck_pin <= 1'b0;
            rxd_pin <= 1'b1;
        end else begin
            rxd_pin <= bit_val;
            if (clk_run) begin
                half_cnt <= (half_cnt == 3) ? 0 : half_cnt + 1;
                if (half_cnt == 3) begin
                    sck_pin <= ~sck_pin;
                end
            end
        end
    end
endmodule : remote_serial_model

// ### verification/testbench.sv
`timescale 1ns/1ps
module testbench;
    import usart_cfg_pkg::*;
    logic ref_clk, rst, hwrite, rxd_pin, sck_pin_in, tx_line, rx_char_start, thr_load;
    logic timeout_tick, bit_val, clk_run, sck_model, rd_dphase;
    logic hreadyout, hresp, txd_pin, rx_line, sck_pin_out, sck_pin_oe, baud_tick;
    logic tx_addr_bit, irq;
    logic [31:0] haddr, hwdata, hrdata, v, m, c, s;
    logic [1:0] htrans;
    logic [9:0] status_in, irq_mask;
    frame_cfg_s frame_cfg;
    int n_mismatch, checks, n_tick, t0;
    logic [31:0] q[$];

    // Clock pin level resolved from both parties; the block wins while it drives
    assign sck_pin_in = sck_pin_oe ? sck_pin_out : sck_model;

    usart_mode_irq #(.TO_WIDTH(8)) usart_mode_irq_inst (
        .ref_clk(ref_clk), .rst(rst), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rxd_pin(rxd_pin),
        .sck_pin_in(sck_pin_in), .tx_line(tx_line), .rx_char_start(rx_char_start),
        .thr_load(thr_load), .timeout_tick(timeout_tick), .status_in(status_in),
        .txd_pin(txd_pin), .rx_line(rx_line), .sck_pin_out(sck_pin_out),
        .sck_pin_oe(sck_pin_oe), .baud_tick(baud_tick), .tx_addr_bit(tx_addr_bit),
        .frame_cfg(frame_cfg), .irq_mask(irq_mask), .irq(irq));

    remote_serial_model remote_serial_model_inst (.ref_clk(ref_clk), .rst(rst),
        .bit_val(bit_val), .clk_run(clk_run), .rxd_pin(rxd_pin), .sck_pin(sck_model));

    task automatic close_out;
        // A read noted but never answered is a failure too
        if (q.size() != 0) begin
            n_mismatch++;
            $display("MISMATCH pending_reads exp 0 got %0d", q.size());
        end
        if (n_mismatch == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : close_out

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    task automatic wait_rdy;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
    endtask : wait_rdy

    // One single transfer; the read's expected word is noted for the monitor
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        if (!wr) q.push_back(d);
        @(posedge ref_clk);
        haddr <= {24'h0, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        wait_rdy();
        htrans <= 2'h0;
        if (wr) hwdata <= d;
        wait_rdy();
    endtask : xfer

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : cyc

    // Single-cycle strobe: 0 char start, 1 holding load, 2 idle tick
    task automatic pulse(input int w);
        @(posedge ref_clk);
        case (w)
            0: rx_char_start <= 1'b1;
            1: thr_load <= 1'b1;
            default: timeout_tick <= 1'b1;
        endcase
        @(posedge ref_clk);
        {rx_char_start, thr_load, timeout_tick} <= 3'h0;
    endtask : pulse

    // Read data is judged in its data phase against the oldest note
    always @(posedge ref_clk) begin
        if (rd_dphase) begin
            if (q.size() == 0) begin
                n_mismatch++;
                $display("MISMATCH hrdata exp none got %h", hrdata);
            end else begin
                chk("hrdata", q.pop_front(), hrdata);
            end
        end
        rd_dphase <= !rst && htrans == HTRANS_NONSEQ && !hwrite && hreadyout;
    end

    always @(posedge ref_clk) begin
        if (baud_tick === 1'b1) n_tick <= n_tick + 1;
    end

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    // Generous bound: the sequence needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_mismatch++;
        close_out();
    end

    initial begin
        rst = 1'b1;
        {htrans, haddr, hwrite, hwdata, status_in} = '0;
        {tx_line, bit_val, clk_run, rx_char_start, thr_load, timeout_tick} = 6'h30;
        rd_dphase = 1'b0;
        void'($urandom(32'hf87b));
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        xfer(0, OFS_MODE, 32'h0);
        xfer(0, OFS_IEN_VIEW, 32'h0);
        xfer(0, 8'h30, 32'h0);
        chk("hresp", 0, hresp);
        v = $urandom();
        xfer(1, OFS_MODE, v);
        xfer(0, OFS_MODE, v & MODE_WR_MASK);
        // Random masks against random status, set then cleared
        repeat (4) begin
            m = $urandom();
            c = $urandom();
            s = $urandom();
            xfer(1, OFS_IEN_SET, m);
            xfer(1, OFS_IEN_VIEW, 32'hffffffff);
            xfer(0, OFS_IEN_VIEW, {22'h0, m[9:0]});
            status_in <= s[9:0];
            cyc(3);
            chk("irq", |(s[9:0] & m[9:0] & 10'h2ff), irq);
            chk("irq_mask", {22'h0, m[9:0]}, irq_mask);
            xfer(1, OFS_IEN_CLR, c);
            xfer(0, OFS_IEN_VIEW, {22'h0, m[9:0] & ~c[9:0]});
            xfer(1, OFS_IEN_CLR, 32'h3ff);
        end
        // Frame format decode over all parity codes
        for (int i = 0; i < 8; i++) begin
            v = ((i % 4) << CHAR_SIZE_LSB) | (i << CHECK_LSB) | ((i % 4) << STOP_LSB);
            v = v | ((i / 4) << SYNC_BIT) | ((i == 7) << NINE_BIT);
            xfer(1, OFS_MODE, v);
            cyc(2);
            chk("data_bits", (i == 7) ? 9 : 5 + i % 4, frame_cfg.data_bits);
            chk("sync_mode", i / 4, frame_cfg.sync_mode);
            chk("multidrop", i >= 6, frame_cfg.multidrop);
            if (i < 4) chk("parity_kind", i, frame_cfg.parity_kind);
            if (i < 6) chk("parity_on", i < 4, frame_cfg.parity_on);
            t0 = (i % 4 == 2) ? 4 : ((i % 4 == 1 && i < 4) ? 3 : 2);
            chk("stop_halves", t0, frame_cfg.stop_halves);
        end
        // Channel routing with pin and transmitter at opposite levels
        for (int i = 0; i < 4; i++) begin
            xfer(1, OFS_MODE, i << LOOP_LSB);
            for (int k = 0; k < 2; k++) begin
                @(posedge ref_clk);
                bit_val <= k[0];
                tx_line <= !k[0];
                cyc(6);
                chk("txd_pin", i == 2 ? 1 : (i == 0 ? !k : k), txd_pin);
                chk("rx_line", i == 3 ? 1 : (i == 2 ? !k : k), rx_line);
            end
        end
        // Baud source counts over a window of whole external periods
        for (int i = 0; i < 3; i++) begin
            xfer(1, OFS_MODE, (i << BAUD_SRC_LSB) | (1 << DRIVE_CLK_BIT));
            clk_run <= (i == 2);
            cyc(20);
            t0 = n_tick;
            cyc(80);
            chk("baud_tick", i == 0 ? 80 : 10, n_tick - t0);
            chk("sck_pin_oe", i < 2, sck_pin_oe);
            // Master source ticks every cycle, so the driven pin flips every cycle
            if (i == 0) begin
                s[0] = sck_pin_out;
                cyc(1);
                chk("sck_pin_out", !s[0], sck_pin_out);
            end
        end
        @(posedge ref_clk);
        clk_run <= 1'b0;
        xfer(1, OFS_MODE, 32'h0);
        cyc(2);
        chk("sck_pin_oe", 0, sck_pin_oe);
        // Idle time-out: ticks before the first character do not count
        @(posedge ref_clk);
        status_in <= 10'h0;
        xfer(1, OFS_TO_VALUE, 32'h3);
        xfer(1, OFS_CTRL, 1 << CTRL_BEGIN_TO_BIT);
        repeat (3) pulse(2);
        xfer(0, OFS_STATUS, 32'h0);
        pulse(0);
        repeat (2) pulse(2);
        xfer(0, OFS_STATUS, 32'h0);
        pulse(2);
        xfer(0, OFS_STATUS, 32'h100);
        xfer(1, OFS_IEN_SET, 32'h100);
        cyc(3);
        chk("irq", 1, irq);
        xfer(1, OFS_TO_VALUE, 32'h0);
        xfer(1, OFS_CTRL, 1 << CTRL_BEGIN_TO_BIT);
        pulse(0);
        repeat (4) pulse(2);
        xfer(0, OFS_STATUS, 32'h0);
        // Address flag only in multidrop, only for the next load
        for (int i = 0; i < 2; i++) begin
            xfer(1, OFS_MODE, i ? 32'h0 : 32'hc00);
            xfer(1, OFS_CTRL, 1 << CTRL_SEND_ADDR_BIT);
            pulse(1);
            cyc(2);
            chk("tx_addr_bit", !i, tx_addr_bit);
            pulse(1);
            cyc(2);
            chk("tx_addr_bit", 0, tx_addr_bit);
        end
        cyc(2);
        close_out();
    end
endmodule : testbench
